/* File: psd_cnt.v */
/*
  Reloading down counter: counts enable pulses, pulses tc on the last
  count of each period and reloads load_val at that moment.
  Assumes load_val is at least 1; a new value takes effect at next reload.
*/
`timescale 1ns/1ps
module psd_cnt #(
  parameter W = 14
) (
  input  wire         clk,
  input  wire         srst,
  input  wire         en,
  input  wire [W-1:0] load_val,
  output wire         tc
);
  reg [W-1:0] cnt_ff;
  reg [W-1:0] nxt_cnt;

  assign tc = en & (cnt_ff <= {{(W-1){1'b0}}, 1'b1});

  always @* begin
    nxt_cnt = cnt_ff;
    if (tc)
      nxt_cnt = load_val;
    else if (en)
      nxt_cnt = cnt_ff - {{(W-1){1'b0}}, 1'b1};
  end

  // Starting at one makes the first enable pulse reload the programmed value
  always @(posedge clk) begin
    if (srst)
      cnt_ff <= {{(W-1){1'b0}}, 1'b1};
    else
      cnt_ff <= nxt_cnt;
  end
endmodule

/* File: psd_defs.vh */
/*
  Constants for the serial-programmed divider and phase detector block:
  APB offsets, field positions, reset values and divider moduli.
  Assumes inclusion by bare name from every design file that needs it.
*/
`ifndef PSD_DEFS_VH
`define PSD_DEFS_VH

// APB byte offsets
`define PSD_OFF_CTRL        12'h000
`define PSD_OFF_REF         12'h004
`define PSD_OFF_MAIN        12'h008
`define PSD_OFF_STATUS      12'h00C

// Serial word layout, control bit shifted last
`define PSD_SR_W            19
`define PSD_CTL_BIT         0
`define PSD_SW_BIT          1
`define PSD_R_LSB           2
`define PSD_R_MSB           15
`define PSD_A_LSB           1
`define PSD_A_MSB           7
`define PSD_N_LSB           8
`define PSD_N_MSB           18

// Field widths
`define PSD_R_W             14
`define PSD_N_W             11
`define PSD_A_W             7
`define PSD_P_W             7

// Latch reset values (smallest legal ratios)
`define PSD_R_RST           14'h0008
`define PSD_N_RST           11'h010
`define PSD_A_RST           7'h00
`define PSD_SW_RST          1'b0

// Prescaler moduli
`define PSD_P_LOW           7'h20
`define PSD_P_HIGH          7'h40

// Lowest legal ratios
`define PSD_R_MIN           14'h0008
`define PSD_N_MIN           11'h010

// Control register reset: counters running
`define PSD_CTRL_RST        1'b1

`endif

/* File: psd_host.sv */
/*
  Host model driving the three-wire serial load port, MSB first.
  Assumes the bench clock; go starts one frame, busy covers it.
*/
`timescale 1ns/1ps
module psd_host (
  input  wire        clk,
  input  wire        go,
  input  wire [18:0] word,
  input  wire [4:0]  nbits,
  output reg         serial_clk,
  output reg         serial_data,
  output reg         latch_load_strobe,
  output reg         busy
);
  int i;
  initial begin
    serial_clk = 1'h0;
    serial_data = 1'h0;
    latch_load_strobe = 1'h0;
    busy = 1'h0;
  end
  // Serial clock stands still between frames; 10 clk is 80 ns
  always begin
    @(posedge clk);
    if (go) begin
      busy <= 1'h1;
      latch_load_strobe <= 1'h0;
      for (i = nbits; i > 0; i--) begin
        serial_data <= word[i-1];
        repeat (5) @(posedge clk);
        serial_clk <= 1'h1;
        repeat (5) @(posedge clk);
        serial_clk <= 1'h0;
      end
      repeat (5) @(posedge clk);
      latch_load_strobe <= 1'h1;
      repeat (10) @(posedge clk);
      latch_load_strobe <= 1'h0;
      // Released data line must not keep its last value
      serial_data <= ~serial_data;
      busy <= 1'h0;
    end
  end
endmodule

/* File: psd_sva.sv */
/*
  Checker for the detector, pump and test outputs of psd_top.
  Assumes it is bound to psd_top and sees that module's ports only.
*/
`timescale 1ns/1ps
module psd_sva (
  input wire clk,
  input wire srst,
  input wire latch_load_strobe,
  input wire phase_polarity_select,
  input wire psel,
  input wire penable,
  input wire pslverr,
  input wire phase_p_out,
  input wire phase_r_out,
  input wire pump_out,
  input wire pump_oe_n,
  input wire bypass_pump_output,
  input wire bypass_pump_oe_n,
  input wire lock_indicator,
  input wire test_out,
  input wire divided_reference,
  input wire divided_vco
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Up and down are cleared together, so both outputs never show active
  property p_no_both; !(!phase_p_out && phase_r_out); endproperty
  a_no_both: assert property (p_no_both) else $error("both detector outputs active");
  property p_lock_nor; lock_indicator == (phase_p_out && !phase_r_out); endproperty
  a_lock_nor: assert property (p_lock_nor) else $error("lock indicator not nor");
  property p_pump_oe; pump_oe_n == lock_indicator; endproperty
  a_pump_oe: assert property (p_pump_oe) else $error("pump enable wrong");
  property p_pump_dir; !pump_oe_n |-> pump_out == !phase_p_out; endproperty
  a_pump_dir: assert property (p_pump_dir) else $error("pump direction wrong");
  // Six cycles cover the pin synchroniser and the output register
  property p_byp_off; (!latch_load_strobe)[*6] |-> bypass_pump_oe_n; endproperty
  a_byp_off: assert property (p_byp_off) else $error("bypass driven with strobe low");
  property p_byp_copy;
    latch_load_strobe[*6] |-> bypass_pump_oe_n == pump_oe_n && (pump_oe_n || bypass_pump_output == pump_out);
  endproperty
  a_byp_copy: assert property (p_byp_copy) else $error("bypass differs from pump");
  property p_test_ref; phase_polarity_select[*6] ##0 divided_reference |-> ##[0:1] test_out; endproperty
  a_test_ref: assert property (p_test_ref) else $error("test output misses reference");
  property p_test_vco; (!phase_polarity_select)[*6] ##0 divided_vco |-> ##[0:1] test_out; endproperty
  a_test_vco: assert property (p_test_vco) else $error("test output misses vco");
  property p_err; pslverr |-> psel && penable; endproperty
  a_err: assert property (p_err) else $error("slave error outside access");
endmodule

bind psd_top psd_sva u_psd_sva (.clk, .srst, .latch_load_strobe, .phase_polarity_select, .psel, .penable,
  .pslverr, .phase_p_out, .phase_r_out, .pump_out, .pump_oe_n, .bypass_pump_output, .bypass_pump_oe_n,
  .lock_indicator, .test_out, .divided_reference, .divided_vco);

/* File: psd_sync.v */
/*
  Two-flop synchroniser with rising-edge detect for a group of pins.
  Assumes inputs are asynchronous to clk; rise is a one-cycle pulse.
*/
`timescale 1ns/1ps
module psd_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         srst,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] level,
  output wire [W-1:0] rise
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;
  reg [W-1:0] prev_ff;

  always @(posedge clk) begin
    if (srst) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
      prev_ff <= {W{1'b0}};
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign level = sync_ff;
  assign rise  = sync_ff & ~prev_ff;
endmodule

/* File: psd_top.v */
/*
  Serial-programmed pulse-swallow divider with phase/frequency detector,
  charge pump drive, lock indicator, test output and APB status access.
  Assumes all pins but the APB ones are asynchronous to clk and much slower than it; the
  oscillator and VCO inputs are already digital squares.
*/
`timescale 1ns/1ps
`include "psd_defs.vh"
module psd_top (
  input  wire        clk,
  input  wire        srst,
  input  wire        serial_clk,
  input  wire        serial_data,
  input  wire        latch_load_strobe,
  input  wire        phase_polarity_select,
  input  wire        oscillator_input,
  input  wire        vco_input,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire [31:0] prdata,
  output wire        pslverr,
  output wire        phase_p_out,
  output wire        phase_r_out,
  output wire        pump_out,
  output wire        pump_oe_n,
  output wire        bypass_pump_output,
  output wire        bypass_pump_oe_n,
  output wire        lock_indicator,
  output wire        test_out,
  output wire        divided_reference,
  output wire        divided_vco
);
  localparam NPIN = 6;
  localparam PI_SCLK = 0;
  localparam PI_SDAT = 1;
  localparam PI_LOAD = 2;
  localparam PI_POL  = 3;
  localparam PI_OSC  = 4;
  localparam PI_VCO  = 5;

  wire [NPIN-1:0] pin_lvl;
  wire [NPIN-1:0] pin_rise;

  // Every pin except the APB ones crosses two flops before any logic looks at it
  psd_sync #(
    .W (NPIN)
  ) u_sync (
    .clk      (clk),
    .srst     (srst),
    .async_in ({vco_input, oscillator_input, phase_polarity_select,
                latch_load_strobe, serial_data, serial_clk}),
    .level    (pin_lvl),
    .rise     (pin_rise)
  );

  wire load_lvl = pin_lvl[PI_LOAD];
  wire pol_hi   = pin_lvl[PI_POL];

  // Serial shift register and bit counter
  reg [`PSD_SR_W-1:0] shift_ff;
  reg [4:0]           bitcnt_ff;
  reg [`PSD_SR_W-1:0] nxt_shift;
  reg [4:0]           nxt_bitcnt;

  always @* begin
    nxt_shift  = shift_ff;
    nxt_bitcnt = bitcnt_ff;
    if (pin_rise[PI_SCLK]) begin
      nxt_shift = {shift_ff[`PSD_SR_W-2:0], pin_lvl[PI_SDAT]};
      if (bitcnt_ff != 5'h1F)
        nxt_bitcnt = bitcnt_ff + 5'h01;
    end
    // Counter restarts at each load so software sees word length
    if (load_lvl)
      nxt_bitcnt = 5'h00;
  end

  always @(posedge clk) begin
    if (srst) begin
      shift_ff  <= {`PSD_SR_W{1'b0}};
      bitcnt_ff <= 5'h00;
    end else begin
      shift_ff  <= nxt_shift;
      bitcnt_ff <= nxt_bitcnt;
    end
  end

  // Latches: transparent while the strobe is high
  reg [`PSD_R_W-1:0] ref_r_ff;
  reg                ref_sw_ff;
  reg [`PSD_N_W-1:0] main_n_ff;
  reg [`PSD_A_W-1:0] main_a_ff;

  always @(posedge clk) begin
    if (srst) begin
      ref_r_ff  <= `PSD_R_RST;
      ref_sw_ff <= `PSD_SW_RST;
      main_n_ff <= `PSD_N_RST;
      main_a_ff <= `PSD_A_RST;
    end else if (load_lvl) begin
      if (shift_ff[`PSD_CTL_BIT]) begin
        ref_r_ff  <= shift_ff[`PSD_R_MSB:`PSD_R_LSB];
        ref_sw_ff <= shift_ff[`PSD_SW_BIT];
      end else begin
        main_n_ff <= shift_ff[`PSD_N_MSB:`PSD_N_LSB];
        main_a_ff <= shift_ff[`PSD_A_MSB:`PSD_A_LSB];
      end
    end
  end

  // Software control: divider run enable
  reg ctrl_run_ff;

  // Reference divider on oscillator edges
  wire ref_tc;

  psd_cnt #(
    .W (`PSD_R_W)
  ) u_ref_cnt (
    .clk      (clk),
    .srst     (srst),
    .en       (pin_rise[PI_OSC] & ctrl_run_ff),
    .load_val (ref_r_ff),
    .tc       (ref_tc)
  );

  // Pulse-swallow divider: a_cnt counts swallow periods still due,
  // each of modulus plus one, then plain periods until n_cnt ends.
  reg  [`PSD_N_W-1:0] n_cnt_ff;
  reg  [`PSD_A_W-1:0] a_cnt_ff;
  reg  [`PSD_N_W-1:0] nxt_n_cnt;
  reg  [`PSD_A_W-1:0] nxt_a_cnt;
  reg  [`PSD_P_W-1:0] pre_mod;
  wire                pre_tc;
  wire                vco_tc;

  wire [`PSD_P_W-1:0] p_base = ref_sw_ff ? `PSD_P_LOW : `PSD_P_HIGH;

  assign vco_tc = pre_tc & (n_cnt_ff <= {{(`PSD_N_W-1){1'b0}}, 1'b1});

  always @* begin
    nxt_n_cnt = n_cnt_ff;
    nxt_a_cnt = a_cnt_ff;
    if (vco_tc) begin
      nxt_n_cnt = main_n_ff;
      nxt_a_cnt = main_a_ff;
    end else if (pre_tc) begin
      nxt_n_cnt = n_cnt_ff - {{(`PSD_N_W-1){1'b0}}, 1'b1};
      if (a_cnt_ff != {`PSD_A_W{1'b0}})
        nxt_a_cnt = a_cnt_ff - {{(`PSD_A_W-1){1'b0}}, 1'b1};
    end
    // Modulus of the period the prescaler reloads for
    if (nxt_a_cnt != {`PSD_A_W{1'b0}})
      pre_mod = p_base + {{(`PSD_P_W-1){1'b0}}, 1'b1};
    else
      pre_mod = p_base;
  end

  always @(posedge clk) begin
    if (srst) begin
      n_cnt_ff <= {{(`PSD_N_W-1){1'b0}}, 1'b1};
      a_cnt_ff <= {`PSD_A_W{1'b0}};
    end else begin
      n_cnt_ff <= nxt_n_cnt;
      a_cnt_ff <= nxt_a_cnt;
    end
  end

  psd_cnt #(
    .W (`PSD_P_W)
  ) u_pre_cnt (
    .clk      (clk),
    .srst     (srst),
    .en       (pin_rise[PI_VCO] & ctrl_run_ff),
    .load_val (pre_mod),
    .tc       (pre_tc)
  );

  // Phase/frequency detector: up means divided VCO is slow
  reg up_ff;
  reg down_ff;
  reg nxt_up;
  reg nxt_down;

  always @* begin
    nxt_up   = up_ff | ref_tc;
    nxt_down = down_ff | vco_tc;
    // Both set: clear together, keeps the 2 pi range and exact duty
    if (nxt_up & nxt_down) begin
      nxt_up   = 1'b0;
      nxt_down = 1'b0;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      up_ff   <= 1'b0;
      down_ff <= 1'b0;
    end else begin
      up_ff   <= nxt_up;
      down_ff <= nxt_down;
    end
  end

  // Output stage, registered
  reg phase_p_ff;
  reg phase_r_ff;
  reg pump_ff;
  reg pump_oe_n_ff;
  reg byp_ff;
  reg byp_oe_n_ff;
  reg lock_ff;
  reg test_ff;
  reg fr_ff;
  reg fp_ff;
  reg nxt_pump;
  reg nxt_pump_oe_n;
  reg nxt_p;
  reg nxt_r;

  always @* begin
    if (pol_hi) begin
      nxt_p = ~up_ff;
      nxt_r = down_ff;
    end else begin
      nxt_p = ~down_ff;
      nxt_r = up_ff;
    end
    nxt_pump      = pol_hi ? up_ff : down_ff;
    nxt_pump_oe_n = ~(up_ff | down_ff);
  end

  always @(posedge clk) begin
    if (srst) begin
      phase_p_ff   <= 1'b1;
      phase_r_ff   <= 1'b0;
      pump_ff      <= 1'b0;
      pump_oe_n_ff <= 1'b1;
      byp_ff       <= 1'b0;
      byp_oe_n_ff  <= 1'b1;
      lock_ff      <= 1'b1;
      test_ff      <= 1'b0;
      fr_ff        <= 1'b0;
      fp_ff        <= 1'b0;
    end else begin
      phase_p_ff   <= nxt_p;
      phase_r_ff   <= nxt_r;
      pump_ff      <= nxt_pump;
      pump_oe_n_ff <= nxt_pump_oe_n;
      byp_ff       <= nxt_pump;
      byp_oe_n_ff  <= load_lvl ? nxt_pump_oe_n : 1'b1;
      lock_ff      <= ~(up_ff | down_ff);
      test_ff      <= pol_hi ? ref_tc : vco_tc;
      fr_ff        <= ref_tc;
      fp_ff        <= vco_tc;
    end
  end

  assign phase_p_out        = phase_p_ff;
  assign phase_r_out        = phase_r_ff;
  assign pump_out           = pump_ff;
  assign pump_oe_n          = pump_oe_n_ff;
  assign bypass_pump_output = byp_ff;
  assign bypass_pump_oe_n   = byp_oe_n_ff;
  assign lock_indicator     = lock_ff;
  assign test_out           = test_ff;
  assign divided_reference  = fr_ff;
  assign divided_vco        = fp_ff;

  // Programming sanity, live flags only: the device still runs with
  // bad values, software just gets to see that the host broke limits
  wire err_r = ref_r_ff < `PSD_R_MIN;
  wire err_n = main_n_ff < `PSD_N_MIN;
  wire err_a = {{(`PSD_N_W-`PSD_A_W){1'b0}}, main_a_ff} >= main_n_ff;

  // APB slave: zero wait states, read data captured in setup phase
  reg [31:0] prdata_ff;
  reg        perr_ff;
  reg [31:0] nxt_rdata;
  reg        nxt_err;

  wire setup = psel & ~penable;
  wire wr_en = psel & penable & pwrite;

  always @* begin
    nxt_rdata = 32'h0000_0000;
    nxt_err   = 1'b0;
    if (paddr == `PSD_OFF_CTRL) begin
      nxt_rdata[0] = ctrl_run_ff;
    end else if (paddr == `PSD_OFF_REF) begin
      nxt_rdata[13:0] = ref_r_ff;
      nxt_rdata[16]   = ref_sw_ff;
    end else if (paddr == `PSD_OFF_MAIN) begin
      nxt_rdata[6:0]   = main_a_ff;
      nxt_rdata[26:16] = main_n_ff;
    end else if (paddr == `PSD_OFF_STATUS) begin
      nxt_rdata[0]    = lock_ff;
      nxt_rdata[1]    = up_ff;
      nxt_rdata[2]    = down_ff;
      nxt_rdata[3]    = pol_hi;
      nxt_rdata[4]    = load_lvl;
      nxt_rdata[5]    = err_r;
      nxt_rdata[6]    = err_n;
      nxt_rdata[7]    = err_a;
      nxt_rdata[12:8] = bitcnt_ff;
    end else begin
      nxt_err = 1'b1;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      prdata_ff   <= 32'h0000_0000;
      perr_ff     <= 1'b0;
      ctrl_run_ff <= `PSD_CTRL_RST;
    end else begin
      if (setup) begin
        prdata_ff <= pwrite ? 32'h0000_0000 : nxt_rdata;
        perr_ff   <= nxt_err;
      end
      if (wr_en && paddr == `PSD_OFF_CTRL)
        ctrl_run_ff <= pwdata[0];
    end
  end

  assign pready  = 1'b1;
  assign prdata  = prdata_ff;
  assign pslverr = perr_ff & psel & penable;
endmodule

/* File: test_psd_top.sv */
/*
  Self-checking bench for psd_top: APB reads, serial loads, divider
  periods and detector activity. Assumes psd_sva is bound separately.
*/
`timescale 1ns/1ps
`include "psd_defs.vh"
module test_psd_top;
  logic        clk     = 1'h0;
  logic        srst    = 1'h1;
  logic        pol_sel = 1'h1;
  logic        osc     = 1'h0;
  logic        vco     = 1'h0;
  logic        psel    = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite  = 1'h0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic        go      = 1'h0;
  logic [18:0] word    = 19'h0_0000;
  logic [4:0]  nbits   = 5'h10;
  logic        win_end = 1'h0;
  wire         sclk, sdata, strobe, busy, pready, pslverr, p_out, r_out, div_ref, div_vco;
  wire  [31:0] prdata;
  int          err_count = 0, checks_done = 0, cyc = 0, rlast = 0, vlast = 0, pcnt = 0, rcnt = 0;
  int          r, n, a;
  logic [32:0] e;
  logic [32:0] rd_q[$];
  int          rp_q[$], vp_q[$];
  logic [1:0]  pf_q[$];

  psd_host u_psd_host (.clk(clk), .go(go), .word(word), .nbits(nbits), .serial_clk(sclk),
    .serial_data(sdata), .latch_load_strobe(strobe), .busy(busy));
  psd_top u_psd_top (.clk(clk), .srst(srst), .serial_clk(sclk), .serial_data(sdata),
    .latch_load_strobe(strobe), .phase_polarity_select(pol_sel), .oscillator_input(osc),
    .vco_input(vco), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .phase_p_out(p_out), .phase_r_out(r_out),
    .pump_out(), .pump_oe_n(), .bypass_pump_output(), .bypass_pump_oe_n(), .lock_indicator(),
    .test_out(), .divided_reference(div_ref), .divided_vco(div_vco));

  always #4 clk = ~clk;

  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task cmp_pfd(input logic [1:0] exp, input logic [1:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch detector activity expected %b seen %b", exp, got);
    end
  endtask

  // Oscillator period 8 clk, VCO period 6 clk (3 clk per level)
  always @(posedge clk) begin
    cyc <= cyc + 1;
    osc <= (cyc % 8) < 4;
    vco <= (cyc % 6) < 3;
    if (cyc == 100000) begin
      err_count++;
      wrap_up;
    end
  end

  always @(posedge clk) begin
    if (psel && penable && pready === 1'h1 && !pwrite) begin
      e = rd_q.pop_front();
      cmp_word("prdata", e[31:0], prdata);
      cmp_word("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
    end
    if (div_ref === 1'h1) begin
      if (rp_q.size() > 0) cmp_word("ref_period", rp_q.pop_front(), cyc - rlast);
      rlast = cyc;
    end
    if (div_vco === 1'h1) begin
      if (vp_q.size() > 0) cmp_word("vco_period", vp_q.pop_front(), cyc - vlast);
      vlast = cyc;
    end
    pcnt += (p_out === 1'h0);
    rcnt += (r_out === 1'h1);
    if (win_end) begin
      if (pf_q.size() > 0) cmp_pfd(pf_q.pop_front(), {pcnt > 0, rcnt > 0});
      pcnt = 0;
      rcnt = 0;
    end
  end

  task apb(input logic wr, input logic [11:0] ad, input logic [31:0] d, input logic [32:0] exp);
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    if (!wr) rd_q.push_back(exp);
    @(posedge clk);
    penable <= 1'h1;
    // Wait on the answer itself; only the global timeout ends a hang
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task send(input logic [18:0] w, input logic [4:0] nb);
    @(posedge clk);
    word <= w;
    nbits <= nb;
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    @(negedge clk);
    while (busy) @(negedge clk);
  endtask

  // Skip two pulses so the new latch values are in force, then note
  task push_period(input logic is_vco, input int exp);
    repeat (2) begin
      @(negedge clk);
      while ((is_vco ? div_vco : div_ref) !== 1'h1) @(negedge clk);
    end
    @(posedge clk);
    @(negedge clk);
    if (is_vco) vp_q.push_back(exp);
    else rp_q.push_back(exp);
  endtask

  task pfd_window(input logic p, input logic [1:0] exp);
    @(posedge clk);
    pol_sel <= p;
    repeat (10) @(posedge clk);
    win_end <= 1'h1;
    @(posedge clk);
    win_end <= 1'h0;
    repeat (5000) @(posedge clk);
    pf_q.push_back(exp);
    win_end <= 1'h1;
    @(posedge clk);
    win_end <= 1'h0;
  endtask

  initial begin
    void'($urandom(32'h439b));
    repeat (12) @(posedge clk);
    srst <= 1'h0;
    apb(1'h0, `PSD_OFF_CTRL, 32'h0, {1'h0, 32'h0000_0001});
    apb(1'h0, `PSD_OFF_REF, 32'h0, {1'h0, 32'h0000_0008});
    apb(1'h0, `PSD_OFF_MAIN, 32'h0, {1'h0, 32'h0010_0000});
    apb(1'h0, 12'h010, 32'h0, {1'h1, 32'h0000_0000});
    apb(1'h1, `PSD_OFF_CTRL, 32'h0, 33'h0);
    apb(1'h0, `PSD_OFF_CTRL, 32'h0, {1'h0, 32'h0000_0000});
    apb(1'h1, `PSD_OFF_CTRL, 32'h0000_0001, 33'h0);
    $display("register test done");
    for (int k = 0; k < 2; k++) begin
      r = 8 + $urandom % 16;
      n = 16 + $urandom % 5;
      a = $urandom % n;
      send({3'h0, r[13:0], k[0], 1'h1}, 5'h10);
      send({n[10:0], a[6:0], 1'h0}, 5'h13);
      apb(1'h0, `PSD_OFF_REF, 32'h0, {1'h0, 15'h0, k[0], 2'h0, r[13:0]});
      apb(1'h0, `PSD_OFF_MAIN, 32'h0, {1'h0, 5'h0, n[10:0], 9'h0, a[6:0]});
      push_period(1'h0, r * 8);
      push_period(1'h1, ((k ? 32 : 64) * n + a) * 6);
      pfd_window(1'h1, 2'h2);
      pfd_window(1'h0, 2'h1);
      $display("round %0d done", k);
    end
    // Reference period above two VCO periods, so only the down side may act
    send({3'h0, 14'h03E8, 1'h1, 1'h1}, 5'h10);
    apb(1'h0, `PSD_OFF_REF, 32'h0, {1'h0, 15'h0, 1'h1, 2'h0, 14'h03E8});
    push_period(1'h0, 8000);
    pfd_window(1'h1, 2'h1);
    pfd_window(1'h0, 2'h2);
    $display("fast vco test done");
    repeat (10) @(posedge clk);
    wrap_up;
  end
endmodule
